// file: inc/stall_arb_pkg.sv
// Package for the slave-port stall arbiter: constants, states and carrier structs.
`default_nettype none
package stall_arb_pkg;

    localparam int unsigned POST_DEPTH   = 4;
    localparam int unsigned WBUS_W       = 32;
    localparam int unsigned ADDR_W       = 32;
    localparam logic [1:0]  TGT_L1       = 2'h0;
    localparam logic [1:0]  TGT_L2       = 2'h1;
    localparam logic [1:0]  TGT_EXT      = 2'h2;
    localparam logic [2:0]  CNT_ZERO     = 3'h0;
    localparam logic [2:0]  CNT_ONE      = 3'h1;

    // Outbound cache activity seen from the level-2 controller.
    typedef struct packed {
        logic l1d_read_miss_ext;
        logic l1d_victim_pend;
        logic l1d_other_pend;
        logic l2_victim_ext;
        logic ext_done;
        logic victim_done;
    } cache_evt_t;

    // One access from the slave port or the internal engine.
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [1:0]        target;
        logic [ADDR_W-1:0] addr;
        logic [WBUS_W-1:0] data;
    } dma_req_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_WAITEXT = 2'b01,
        ST_WAITBTH = 2'b11
    } hold_state_t;

endpackage
`default_nettype wire

// file: rtl/slave_dma_stall_arbiter.sv
// Arbiter that holds slave-port and internal-engine accesses behind outbound traffic.
//
// Functional notes
// RQ1: Posting buffer keeps at most four pending non-cacheable external writes.
// RQ2: Full posting buffer blocks slave-port and internal-engine traffic until one drains.
// RQ3: Read miss to external with victim holds traffic until both finish.
// RQ4: External read miss while another request pends holds until external read ends.
// RQ5: Level-2 victim during pending request holds until both complete.
// RQ6: Stalled slave port shows not-ready and refuses write data.
// RQ7: Later bridged external writes queue behind an earlier slave-port write.
// RQ8: Descriptor RAM transfers use word accesses with four-byte strides (other party).
// RQ9: Level-2 fully cache removes the extra stalls and the deadlock.
// RQ10: Level-1 accesses stall only when queued behind level-2 accesses.
// RQ11: Internal engine shares resources, so blocking applies equally to both.
// RQ12: A read to the same memory forces that master's pending writes out.
// RQ13: Held accesses resume in order, without loss or duplication.
`timescale 1ns/1ps
`default_nettype none

module slave_dma_stall_arbiter #(
    parameter int unsigned DEPTH = stall_arb_pkg::POST_DEPTH
) (
    input  wire logic                              mclk,
    input  wire logic                              rstn,
    input  wire logic                              l2_all_cache,
    input  wire stall_arb_pkg::cache_evt_t         cache_evt,
    input  wire logic                              nc_wr_valid,
    input  wire logic [stall_arb_pkg::WBUS_W-1:0]  nc_wr_data,
    output logic                                   nc_wr_ready,
    output logic                                   master_dma_path_valid,
    output logic [stall_arb_pkg::WBUS_W-1:0]       master_dma_path_data,
    input  wire logic                              master_dma_path_ready,
    input  wire stall_arb_pkg::dma_req_t           slave_dma_port_req,
    output logic                                   slave_dma_port_ready,
    input  wire stall_arb_pkg::dma_req_t           internal_dma_engine_req,
    output logic                                   internal_dma_engine_ready,
    input  wire logic                              bridged_ext_wr_req,
    input  wire logic                              bridged_read_same_dest,
    output logic                                   bridged_ext_wr_grant,
    output var stall_arb_pkg::dma_req_t            mem_req,
    output logic                                   stall_active
);

    localparam int unsigned PW = $clog2(DEPTH);

    // Posting buffer state.
    logic [stall_arb_pkg::WBUS_W-1:0] post_mem [DEPTH];
    logic [PW-1:0]                    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [PW:0]                      cnt_r, cnt_nxt;
    logic                             full;
    logic                             push, pop;

    // Hold state for cache-driven stalls.
    stall_arb_pkg::hold_state_t       hs_r, hs_nxt;
    logic                             hold_l2_r, hold_l2_nxt;
    logic                             ext_seen_r, ext_seen_nxt;
    logic                             oth_seen_r, oth_seen_nxt;

    // Output and fabric ordering state.
    stall_arb_pkg::dma_req_t          mem_req_nxt;
    logic                             slave_dma_port_rdy_nxt, internal_dma_engine_rdy_nxt, stall_nxt;
    logic                             slave_dma_port_wr_open_r, slave_dma_port_wr_open_nxt;
    logic                             grant_nxt;
    logic                             mvalid_nxt;
    logic [stall_arb_pkg::WBUS_W-1:0] mdata_nxt;
    logic                             block, l2_queued, pick_slave_dma_port;

    function automatic logic is_l2(input stall_arb_pkg::dma_req_t r);
        return r.valid && (r.target == stall_arb_pkg::TGT_L2);
    endfunction

    // Posting buffer: full at DEPTH entries, drains onto the master path.
    always_comb begin
        full    = (cnt_r == (PW+1)'(DEPTH)); // RQ1
        push    = nc_wr_valid && !full; // RQ1
        pop     = master_dma_path_valid && master_dma_path_ready;
        wp_nxt  = push ? PW'(wp_r + 1'b1) : wp_r;
        rp_nxt  = pop ? PW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = (PW+1)'(cnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push) begin
            post_mem[wp_r] <= nc_wr_data;
        end
    end

    // Cache hold machine; holds are only armed while level 2 holds RAM.
    always_comb begin
        hs_nxt       = hs_r;
        hold_l2_nxt  = hold_l2_r;
        ext_seen_nxt = ext_seen_r;
        oth_seen_nxt = oth_seen_r;
        unique case (hs_r)
            stall_arb_pkg::ST_IDLE: begin
                if (!l2_all_cache) begin // RQ9
                    if (cache_evt.l1d_read_miss_ext && cache_evt.l1d_victim_pend) begin
                        hs_nxt       = stall_arb_pkg::ST_WAITBTH; // RQ3
                        ext_seen_nxt = 1'b0;
                        oth_seen_nxt = 1'b0;
                    end else if (cache_evt.l2_victim_ext && cache_evt.l1d_other_pend) begin
                        hs_nxt       = stall_arb_pkg::ST_WAITBTH; // RQ5
                        ext_seen_nxt = 1'b0;
                        oth_seen_nxt = 1'b0;
                    end else if (cache_evt.l1d_read_miss_ext && cache_evt.l1d_other_pend) begin
                        hs_nxt = stall_arb_pkg::ST_WAITEXT; // RQ4
                    end
                end
            end
            stall_arb_pkg::ST_WAITEXT: begin
                if (cache_evt.ext_done) begin
                    hs_nxt = stall_arb_pkg::ST_IDLE; // RQ4
                end
            end
            stall_arb_pkg::ST_WAITBTH: begin
                ext_seen_nxt = ext_seen_r || cache_evt.ext_done;
                oth_seen_nxt = oth_seen_r || cache_evt.victim_done;
                if (ext_seen_nxt && oth_seen_nxt) begin
                    hs_nxt = stall_arb_pkg::ST_IDLE; // RQ3 RQ5
                end
            end
        endcase
        // A level-1 access stalls only while level-2 accesses are queued ahead.
        if (is_l2(slave_dma_port_req) || is_l2(internal_dma_engine_req)) begin
            hold_l2_nxt = 1'b1; // RQ10
        end else if (!slave_dma_port_req.valid && !internal_dma_engine_req.valid) begin
            hold_l2_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            hs_r       <= stall_arb_pkg::ST_IDLE;
            hold_l2_r  <= 1'b0;
            ext_seen_r <= 1'b0;
            oth_seen_r <= 1'b0;
        end else begin
            hs_r       <= hs_nxt;
            hold_l2_r  <= hold_l2_nxt;
            ext_seen_r <= ext_seen_nxt;
            oth_seen_r <= oth_seen_nxt;
        end
    end

    // Shared access port: one block term for both sources, slave port first.
    // A request is taken only when its ready is high, so a held one is
    // presented again unchanged and nothing is lost or repeated.
    always_comb begin
        l2_queued = hold_l2_r || is_l2(slave_dma_port_req) || is_l2(internal_dma_engine_req);
        block     = !l2_all_cache && l2_queued
                    && (full || (hs_r != stall_arb_pkg::ST_IDLE)); // RQ2 RQ9 RQ10 RQ11
        pick_slave_dma_port = slave_dma_port_req.valid;
        // Only one source is offered ready at a time, so both can never be
        // taken at one edge with the engine's access silently dropped.
        slave_dma_port_rdy_nxt = !block && (pick_slave_dma_port || !internal_dma_engine_req.valid); // RQ6 RQ11
        internal_dma_engine_rdy_nxt = !block && !pick_slave_dma_port && internal_dma_engine_req.valid; // RQ11 RQ13
        mem_req_nxt  = '0;
        if (slave_dma_port_req.valid && slave_dma_port_ready) begin
            mem_req_nxt = slave_dma_port_req; // RQ13
        end else if (internal_dma_engine_req.valid && internal_dma_engine_ready) begin
            mem_req_nxt = internal_dma_engine_req; // RQ13
        end
        stall_nxt = block;
        // A slave-port write held by a stall keeps later bridged external
        // writes waiting; a read to the same memory flushes it first.
        slave_dma_port_wr_open_nxt = slave_dma_port_wr_open_r;
        if (bridged_read_same_dest) begin
            slave_dma_port_wr_open_nxt = 1'b0; // RQ12
        end else if (slave_dma_port_req.valid && slave_dma_port_req.write && block) begin
            slave_dma_port_wr_open_nxt = 1'b1; // RQ7
        end else if (!block) begin
            slave_dma_port_wr_open_nxt = 1'b0;
        end
        grant_nxt  = bridged_ext_wr_req && !slave_dma_port_wr_open_nxt; // RQ7
        mvalid_nxt = (cnt_nxt != '0);
        // A word pushed into an empty buffer is not in the array until this
        // edge, so it is forwarded straight to the head register.
        if (push && (wp_r == rp_nxt)) begin
            mdata_nxt = nc_wr_data;
        end else begin
            mdata_nxt = post_mem[rp_nxt];
        end
    end

    // Registered outputs.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            slave_dma_port_ready      <= 1'b0;
            internal_dma_engine_ready <= 1'b0;
            mem_req                   <= '0;
            stall_active              <= 1'b0;
            slave_dma_port_wr_open_r            <= 1'b0;
            bridged_ext_wr_grant      <= 1'b0;
            master_dma_path_valid     <= 1'b0;
            master_dma_path_data      <= '0;
            nc_wr_ready               <= 1'b0;
        end else begin
            slave_dma_port_ready      <= slave_dma_port_rdy_nxt;
            internal_dma_engine_ready <= internal_dma_engine_rdy_nxt;
            mem_req                   <= mem_req_nxt;
            stall_active              <= stall_nxt;
            slave_dma_port_wr_open_r            <= slave_dma_port_wr_open_nxt;
            bridged_ext_wr_grant      <= grant_nxt;
            master_dma_path_valid     <= mvalid_nxt;
            master_dma_path_data      <= mdata_nxt;
            nc_wr_ready               <= (cnt_nxt != (PW+1)'(DEPTH)); // RQ1
        end
    end

endmodule

`default_nettype wire

// file: test/fabric_master_model.sv
// Fabric master model that issues four word-stride writes toward the slave port.
`timescale 1ns/1ps
`default_nettype none
module fabric_master_model (
    input  wire logic              mclk, go, ready,
    input  wire logic [1:0]        tgt,
    output var stall_arb_pkg::dma_req_t req
);
    logic [2:0] left_r;
    initial req = '0;
    // Every field holds until the edge that takes it, then address and data step one word.
    // Word strides keep word-only memories such as descriptor RAM usable.
    always @(posedge mclk) begin
        if (go) begin
            left_r <= 3'h4;
            req    <= '{1'b1, 1'b1, tgt, 32'h0, 32'h5a5a_0000};
        end else if (req.valid && ready) begin
            left_r    <= left_r - 3'h1;
            req.valid <= left_r != 3'h1;
            req.addr  <= req.addr + 32'h4;
            req.data  <= req.data + 32'h4;
        end
    end
endmodule
`default_nettype wire

// file: test/stall_arb_chk.sv
// Port checker for the stall arbiter, bound to it below.
`timescale 1ns/1ps
`default_nettype none
module stall_arb_chk (
    input wire logic mclk, rstn, l2_all_cache, nc_wr_valid, nc_wr_ready,
    input wire logic master_dma_path_valid, master_dma_path_ready, slave_dma_port_ready,
    input wire logic internal_dma_engine_ready, bridged_ext_wr_req, bridged_read_same_dest,
    input wire logic bridged_ext_wr_grant, stall_active,
    input wire stall_arb_pkg::dma_req_t slave_dma_port_req, internal_dma_engine_req, mem_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // A forwarded access must trace back to a request taken one edge earlier.
    wire take = (slave_dma_port_req.valid && slave_dma_port_ready)
        || (internal_dma_engine_req.valid && internal_dma_engine_ready);
    sequence s_four_acc; (nc_wr_valid && nc_wr_ready && !master_dma_path_ready)[*4]; endsequence
    sequence s_held_wr;
        (slave_dma_port_req.valid && slave_dma_port_req.write && stall_active
            && !bridged_read_same_dest)[*2];
    endsequence
    property p_post_depth; s_four_acc |=> !nc_wr_ready; endproperty
    a_post_depth: assert property (p_post_depth) else $error("fifth post taken");
    property p_drain; !nc_wr_ready && master_dma_path_valid && master_dma_path_ready
        && !nc_wr_valid |=> nc_wr_ready; endproperty
    a_drain: assert property (p_drain) else $error("no room after drain");
    property p_blocked; stall_active |-> !slave_dma_port_ready && !internal_dma_engine_ready;
    endproperty
    a_blocked: assert property (p_blocked) else $error("ready during stall");
    property p_all_cache; l2_all_cache |=> !stall_active; endproperty
    a_all_cache: assert property (p_all_cache) else $error("stall in all-cache mode");
    property p_take; slave_dma_port_req.valid && slave_dma_port_ready
        |=> mem_req == $past(slave_dma_port_req); endproperty
    a_take: assert property (p_take) else $error("taken access not forwarded");
    property p_no_dup; mem_req.valid |-> $past(take); endproperty
    a_no_dup: assert property (p_no_dup) else $error("access forwarded twice");
    property p_bridge; s_held_wr |-> !bridged_ext_wr_grant; endproperty
    a_bridge: assert property (p_bridge) else $error("bridged write passed");
    property p_force; (bridged_ext_wr_req && bridged_read_same_dest)[*2]
        |-> bridged_ext_wr_grant; endproperty
    a_force: assert property (p_force) else $error("read did not force writes");
endmodule
bind slave_dma_stall_arbiter stall_arb_chk chk_u (.*);
`default_nettype wire

// file: test/slave_dma_stall_arbiter_bench.sv
// Self-checking bench for the slave-port stall arbiter.
`timescale 1ns/1ps
`default_nettype none
module slave_dma_stall_arbiter_bench;
    logic                      mclk, rstn, l2_all_cache, go, nc_wr_valid, nc_wr_ready;
    logic                      mdp_valid, mdp_ready, s_rdy, e_rdy, br_req, br_rd, br_gnt, stall;
    logic [1:0]                tgt;
    logic [31:0]               nc_wr_data, mdp_data;
    logic [31:0]               seen [32];
    logic [31:0]               pops [10];
    stall_arb_pkg::cache_evt_t cache_evt;
    stall_arb_pkg::dma_req_t   s_req, e_req, mem_req;
    int                        nseen = 0, npop = 0, cyc = 0, miscompares = 0, total_checks = 0;
    slave_dma_stall_arbiter dut_u (.mclk(mclk), .rstn(rstn), .l2_all_cache(l2_all_cache),
        .cache_evt(cache_evt), .nc_wr_valid(nc_wr_valid), .nc_wr_data(nc_wr_data),
        .nc_wr_ready(nc_wr_ready), .master_dma_path_valid(mdp_valid),
        .master_dma_path_data(mdp_data), .master_dma_path_ready(mdp_ready),
        .slave_dma_port_req(s_req), .slave_dma_port_ready(s_rdy),
        .internal_dma_engine_req(e_req), .internal_dma_engine_ready(e_rdy),
        .bridged_ext_wr_req(br_req), .bridged_read_same_dest(br_rd),
        .bridged_ext_wr_grant(br_gnt), .mem_req(mem_req), .stall_active(stall));
    fabric_master_model fm_u (.mclk(mclk), .go(go), .ready(s_rdy), .tgt(tgt), .req(s_req));
    // Log forwarded accesses and outbound pops; the cycle ceiling cuts a hang short.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (mem_req.valid === 1'b1) begin
            seen[nseen] <= mem_req.addr;
            nseen <= nseen + 1;
        end
        if (mdp_valid && mdp_ready && npop < 10) begin
            pops[npop] <= mdp_data;
            npop <= npop + 1;
        end
        if (cyc == 2000) begin
            miscompares++;
            finish_test();
        end
    end
    task chk(input logic c, input string m);
        total_checks++;
        if (c !== 1'b1) begin
            miscompares++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task cyc_n(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Posts four outbound writes; the caller keeps the outbound side stalled.
    task fill;
        for (int i = 0; i < 4; i++) begin
            nc_wr_data <= 32'h1000_0000 + i;
            nc_wr_valid <= 1'b1;
            @(posedge mclk);
        end
        nc_wr_valid <= 1'b0;
    endtask
    task launch(input logic [1:0] t);
        tgt <= t;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask
    task t_post;
        fill();
        launch(stall_arb_pkg::TGT_L2);
        cyc_n(4);
        chk(nc_wr_ready === 1'b0, "fifth post room");
        chk(stall === 1'b1 && s_rdy === 1'b0, "port not held");
        e_req <= '{1'b1, 1'b0, stall_arb_pkg::TGT_L2, 32'h100, 32'h0};
        br_req <= 1'b1;
        cyc_n(3);
        chk(e_rdy === 1'b0 && nseen < 2, "access passed a stall");
        chk(br_gnt === 1'b0, "bridged write passed");
        br_rd <= 1'b1;
        cyc_n(3);
        chk(br_gnt === 1'b1, "read did not force");
        mdp_ready <= 1'b1;
        // The engine request stays up until the edge that takes it.
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            if (e_req.valid && e_rdy) e_req.valid <= 1'b0;
        end
        br_req <= 1'b0;
        br_rd <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            chk(pops[i] === 32'h1000_0000 + i, "post order");
            chk(seen[i] === 32'(i * 4), "port write order");
        end
        chk(seen[4] === 32'h100 && nseen == 5, "engine access lost");
        $display("test post done");
    endtask
    task t_cache;
        logic [3:0] lv [3] = '{4'hc, 4'ha, 4'h3};
        for (int k = 0; k < 3; k++) begin
            cache_evt <= {lv[k], 2'b00};
            launch(stall_arb_pkg::TGT_L2);
            cache_evt <= '0;
            cyc_n(4);
            chk(stall === 1'b1, "miss did not hold");
            cache_evt.ext_done <= 1'b1;
            @(posedge mclk);
            cache_evt.ext_done <= 1'b0;
            cyc_n(2);
            chk(stall === (k != 1), "hold end");
            cache_evt.victim_done <= 1'b1;
            @(posedge mclk);
            cache_evt.victim_done <= 1'b0;
            cyc_n(12);
        end
        chk(nseen == 17, "held access lost");
        $display("test cache done");
    endtask
    task t_all_cache;
        l2_all_cache <= 1'b1;
        mdp_ready <= 1'b0;
        fill();
        launch(stall_arb_pkg::TGT_L2);
        cyc_n(8);
        chk(nseen == 21 && stall === 1'b0, "all-cache stall");
        l2_all_cache <= 1'b0;
        launch(stall_arb_pkg::TGT_L1);
        cyc_n(8);
        chk(nseen == 25 && stall === 1'b0, "level-1 stall");
        mdp_ready <= 1'b1;
        cyc_n(8);
        for (int i = 0; i < 4; i++) begin
            chk(pops[4 + i] === 32'h1000_0000 + i, "held post order");
        end
        // A single post into an empty buffer must leave with its own data.
        nc_wr_data <= 32'h2000_0000;
        nc_wr_valid <= 1'b1;
        @(posedge mclk);
        nc_wr_valid <= 1'b0;
        cyc_n(4);
        chk(npop == 9 && pops[8] === 32'h2000_0000, "bypass data");
        $display("test all cache done");
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {rstn, l2_all_cache, go, nc_wr_valid, mdp_ready, br_req, br_rd} = '0;
        {tgt, nc_wr_data, cache_evt, e_req} = '0;
        cyc_n(16);
        rstn <= 1'b1;
        cyc_n(2);
        t_post();
        t_cache();
        t_all_cache();
        finish_test();
    end
endmodule
`default_nettype wire
